// file: tws_timer_watchdog.sv
// Main timer with prescaler, watchdog with prescaler, reset sequencing,
// sleep entry and port-change wake, reached by software over APB.
// Assumes synchronous pins and a core clock that stays alive in sleep.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module tws_timer_watchdog #(
  parameter int unsigned WDT_TICK_CYC   = tws_pkg::WDT_TICK_CYC,
  parameter int unsigned START_HOLD_CYC = tws_pkg::START_HOLD_CYC,
  parameter int unsigned PORT_W         = 8,
  parameter int unsigned PC_W           = 10
) (
  // Clock and power-on reset
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output logic [31:0]            o_prdata,
  // Pins
  input  wire logic              i_ext_reset_n,
  input  wire logic              i_timer_pin,
  input  wire logic [PORT_W-1:0] i_port2_in,
  // Core side status
  output logic                   o_device_reset,
  output logic                   o_ports_hiz,
  output logic                   o_sleep,
  output logic                   o_wake_pulse,
  output logic [PC_W-1:0]        o_program_counter,
  output logic [7:0]             o_pull_down_ctrl,
  output logic [7:0]             o_open_drain_ctrl,
  output logic [7:0]             o_pull_up_ctrl
);

  // Prescaler tap: ratio is 2^(sel+1), hit when low bits are all ones
  function automatic logic presc_hit(input logic [7:0] cnt,
                                     input logic [2:0] sel);
    logic [7:0] msk;
    msk = 8'hFF >> (3'h7 - sel);
    presc_hit = ((cnt & msk) == msk);
  endfunction : presc_hit

  localparam logic [22:0] HOLD_LOAD = 23'(START_HOLD_CYC - 1);
  localparam logic [15:0] TICK_LOAD = 16'(WDT_TICK_CYC - 1);

  logic [7:0]        option_control_reg;
  logic [7:0]        watchdog_ctrl_reg;
  logic [7:0]        timer_count_reg;
  logic [7:0]        status_flags_reg;
  logic [7:0]        irq_flag_reg;
  logic [7:0]        irq_mask_reg;
  logic [7:0]        pull_down_ctrl_reg;
  logic [7:0]        open_drain_ctrl_reg;
  logic [7:0]        pull_up_ctrl_reg;
  logic [PORT_W-1:0] port2_ref_reg;
  logic [PC_W-1:0]   program_counter_reg;
  logic [7:0]        timer_presc_reg;
  logic [7:0]        wdt_presc_reg;
  logic [7:0]        wdt_count_reg;
  logic [15:0]       osc_div_reg;
  logic [22:0]       hold_cnt_reg;
  logic              hold_reg;
  logic              sleep_reg;
  logic              irq_on_reg;
  logic              pin_prev_reg;
  logic [31:0]       prdata_reg;

  // Bus decode
  logic wr_acc;
  logic rd_acc;
  logic setup_rd;
  logic mapped;
  logic [7:0] wdat;
  assign wr_acc   = i_psel & i_penable & i_pwrite;
  assign rd_acc   = i_psel & i_penable & ~i_pwrite;
  assign setup_rd = i_psel & ~i_penable & ~i_pwrite;
  assign wdat     = i_pwdata[7:0];

  always_comb begin
    case (i_paddr)
      tws_pkg::OFS_OPTION_CTRL, tws_pkg::OFS_WDT_CTRL,
      tws_pkg::OFS_TIMER_COUNT, tws_pkg::OFS_STATUS_FLAGS,
      tws_pkg::OFS_IRQ_FLAG, tws_pkg::OFS_IRQ_MASK,
      tws_pkg::OFS_PULL_DOWN, tws_pkg::OFS_OPEN_DRAIN,
      tws_pkg::OFS_PULL_UP, tws_pkg::OFS_PORT2_DATA,
      tws_pkg::OFS_COMMAND, tws_pkg::OFS_PROG_COUNTER: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Software writes are ignored while the device is held in reset
  logic wr_ok;
  assign wr_ok = wr_acc & mapped & ~hold_reg;

  function automatic logic wr_to(input logic [7:0] ofs,
                                 input logic       ok,
                                 input logic [7:0] addr);
    wr_to = ok && (addr == ofs);
  endfunction : wr_to

  logic cmd_wr;
  logic clr_wdt_cmd;
  logic sleep_cmd;
  assign cmd_wr      = wr_to(tws_pkg::OFS_COMMAND, wr_ok, i_paddr);
  assign clr_wdt_cmd = cmd_wr & i_pwdata[tws_pkg::CMD_CLRWDT_BIT];
  assign sleep_cmd   = cmd_wr & i_pwdata[tws_pkg::CMD_SLEEP_BIT];

  // Watchdog oscillator, modelled as a free divider of the core clock
  logic osc_tick;
  assign osc_tick = (osc_div_reg == TICK_LOAD);
  always_ff @(posedge i_core_clk) begin
    if (i_reset || osc_tick) begin
      osc_div_reg <= 16'h0000;
    end else begin
      osc_div_reg <= osc_div_reg + 16'h0001;
    end
  end

  // Watchdog prescaler and counter
  logic wdt_en;
  logic wdt_psel_en;
  logic wdt_step;
  logic wdt_timeout;
  logic wdt_clear;
  assign wdt_en      = watchdog_ctrl_reg[tws_pkg::WDC_EN_BIT];
  assign wdt_psel_en = watchdog_ctrl_reg[tws_pkg::WDC_PSE_BIT];
  assign wdt_step    = osc_tick & (~wdt_psel_en | presc_hit(wdt_presc_reg,
                       watchdog_ctrl_reg[tws_pkg::WDC_PSEL_LSB +: 3]));
  assign wdt_timeout = wdt_en & ~hold_reg & wdt_step
                       & (wdt_count_reg == 8'hFF);
  assign wdt_clear   = hold_reg | clr_wdt_cmd | sleep_cmd;

  always_ff @(posedge i_core_clk) begin
    if (i_reset || wdt_clear) begin
      wdt_presc_reg <= 8'h00;
    end else if (osc_tick && wdt_en) begin
      wdt_presc_reg <= wdt_presc_reg + 8'h01;
    end
  end

  // Counts in sleep too, since only the core clock is modelled
  always_ff @(posedge i_core_clk) begin
    if (i_reset || wdt_clear) begin
      wdt_count_reg <= 8'h00;
    end else if (wdt_step && wdt_en) begin
      wdt_count_reg <= wdt_count_reg + 8'h01;
    end
  end

  // Reset sources and start-up hold
  logic rst_event;
  assign rst_event = ~i_ext_reset_n | wdt_timeout;

  always_ff @(posedge i_core_clk) begin
    if (i_reset || rst_event) begin
      hold_reg     <= 1'b1;
      hold_cnt_reg <= HOLD_LOAD;
    end else if (hold_cnt_reg != 23'h000000) begin
      hold_cnt_reg <= hold_cnt_reg - 23'h000001;
    end else begin
      hold_reg     <= 1'b0;
    end
  end

  // Port change detect, reference taken on every port read
  logic port_rd;
  logic port_change;
  assign port_rd     = rd_acc & (i_paddr == tws_pkg::OFS_PORT2_DATA);
  assign port_change = (i_port2_in != port2_ref_reg);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      port2_ref_reg <= '0;
    end else if (port_rd) begin
      port2_ref_reg <= i_port2_in;
    end
  end

  // Sleep and wake
  logic wake_chg;
  assign wake_chg = sleep_reg & port_change
                    & irq_mask_reg[tws_pkg::IRQ_CHG_BIT];

  always_ff @(posedge i_core_clk) begin
    if (i_reset || hold_reg) begin
      sleep_reg <= 1'b0;
    end else if (wake_chg) begin
      sleep_reg <= 1'b0;
    end else if (sleep_cmd) begin
      sleep_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset || hold_reg) begin
      irq_on_reg <= 1'b0;
    end else if (cmd_wr && i_pwdata[tws_pkg::CMD_IRQ_ON_BIT]) begin
      irq_on_reg <= 1'b1;
    end else if (cmd_wr && i_pwdata[tws_pkg::CMD_IRQ_OFF_BIT]) begin
      irq_on_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset || hold_reg) begin
      program_counter_reg <= '0;
    end else if (wake_chg && irq_on_reg) begin
      program_counter_reg <= PC_W'(tws_pkg::WAKE_VECTOR);
    end else if (wr_to(tws_pkg::OFS_PROG_COUNTER, wr_ok, i_paddr)) begin
      program_counter_reg <= PC_W'(i_pwdata);
    end
  end

  // Main timer: prescaler and count; stopped while asleep
  logic tmr_ext;
  logic pin_edge;
  logic tmr_src;
  logic tmr_inc;
  logic tmr_wr;
  assign tmr_ext  = option_control_reg[tws_pkg::OPT_SRC_BIT];
  assign pin_edge = option_control_reg[tws_pkg::OPT_EDGE_BIT]
                    ? (pin_prev_reg & ~i_timer_pin)
                    : (~pin_prev_reg & i_timer_pin);
  assign tmr_src  = (tmr_ext ? pin_edge : 1'b1) & ~sleep_reg & ~hold_reg;
  assign tmr_inc  = tmr_src & (option_control_reg[tws_pkg::OPT_BYPASS_BIT]
                    | presc_hit(timer_presc_reg,
                      option_control_reg[tws_pkg::OPT_PSEL_LSB +: 3]));
  assign tmr_wr   = wr_to(tws_pkg::OFS_TIMER_COUNT, wr_ok, i_paddr);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= i_timer_pin;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset || hold_reg || tmr_wr) begin
      timer_presc_reg <= 8'h00;
    end else if (tmr_src) begin
      timer_presc_reg <= timer_presc_reg + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset || hold_reg) begin
      timer_count_reg <= 8'h00;
    end else if (tmr_wr) begin
      timer_count_reg <= wdat;
    end else if (tmr_inc) begin
      timer_count_reg <= timer_count_reg + 8'h01;
    end
  end

  // Option and watchdog control
  always_ff @(posedge i_core_clk) begin
    if (i_reset || hold_reg) begin
      option_control_reg <= tws_pkg::RST_OPTION_CTRL;
    end else if (wr_to(tws_pkg::OFS_OPTION_CTRL, wr_ok, i_paddr)) begin
      option_control_reg <= wdat;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset || hold_reg) begin
      watchdog_ctrl_reg <= tws_pkg::RST_WDT_CTRL;
    end else if (wake_chg) begin
      watchdog_ctrl_reg[tws_pkg::WDC_EN_BIT] <= 1'b1;
    end else if (wr_to(tws_pkg::OFS_WDT_CTRL, wr_ok, i_paddr)) begin
      watchdog_ctrl_reg <= wdat & tws_pkg::WDC_WMASK;
    end
  end

  // Pin configuration registers
  always_ff @(posedge i_core_clk) begin
    if (i_reset || hold_reg) begin
      pull_down_ctrl_reg  <= tws_pkg::RST_PULL_DOWN;
      open_drain_ctrl_reg <= tws_pkg::RST_OPEN_DRAIN;
      pull_up_ctrl_reg    <= tws_pkg::RST_PULL_UP;
    end else begin
      if (wr_to(tws_pkg::OFS_PULL_DOWN, wr_ok, i_paddr)) begin
        pull_down_ctrl_reg <= wdat;
      end
      if (wr_to(tws_pkg::OFS_OPEN_DRAIN, wr_ok, i_paddr)) begin
        open_drain_ctrl_reg <= wdat;
      end
      if (wr_to(tws_pkg::OFS_PULL_UP, wr_ok, i_paddr)) begin
        pull_up_ctrl_reg <= wdat;
      end
    end
  end

  // Interrupt mask and sticky flags; hardware set beats software clear
  always_ff @(posedge i_core_clk) begin
    if (i_reset || hold_reg) begin
      irq_mask_reg <= tws_pkg::RST_IRQ;
    end else if (wr_to(tws_pkg::OFS_IRQ_MASK, wr_ok, i_paddr)) begin
      irq_mask_reg <= wdat & tws_pkg::IRQ_WMASK;
    end
  end

  logic [7:0] irq_set;
  always_comb begin
    irq_set = 8'h00;
    irq_set[tws_pkg::IRQ_TMR_BIT] = tmr_inc & (timer_count_reg == 8'hFF)
                                    & ~tmr_wr;
    irq_set[tws_pkg::IRQ_CHG_BIT] = port_change
                                    & irq_mask_reg[tws_pkg::IRQ_CHG_BIT];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset || hold_reg) begin
      irq_flag_reg <= tws_pkg::RST_IRQ;
    end else if (wr_to(tws_pkg::OFS_IRQ_FLAG, wr_ok, i_paddr)) begin
      irq_flag_reg <= (wdat & tws_pkg::IRQ_WMASK) | irq_set;
    end else begin
      irq_flag_reg <= irq_flag_reg | irq_set;
    end
  end

  // Status flags: time-out and power-down mark the reset or wake cause
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      status_flags_reg <= tws_pkg::RST_STATUS;
    end else if (wdt_timeout) begin
      status_flags_reg[tws_pkg::STS_TO_BIT] <= 1'b0;
      status_flags_reg[tws_pkg::STS_PD_BIT] <= ~sleep_reg;
    end else if (~i_ext_reset_n) begin
      status_flags_reg[tws_pkg::STS_TO_BIT] <= 1'b1;
      status_flags_reg[tws_pkg::STS_PD_BIT] <= ~sleep_reg;
    end else if (sleep_cmd) begin
      status_flags_reg[tws_pkg::STS_TO_BIT] <= 1'b1;
      status_flags_reg[tws_pkg::STS_PD_BIT] <= 1'b0;
    end else if (clr_wdt_cmd) begin
      status_flags_reg[tws_pkg::STS_TO_BIT] <= 1'b1;
      status_flags_reg[tws_pkg::STS_PD_BIT] <= 1'b1;
    end else if (wr_to(tws_pkg::OFS_STATUS_FLAGS, wr_ok, i_paddr)) begin
      status_flags_reg <= (wdat & tws_pkg::STS_WMASK)
                          | (status_flags_reg & ~tws_pkg::STS_WMASK);
    end
  end

  // Read data is captured in the setup cycle so it stands in access
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (i_paddr)
      tws_pkg::OFS_OPTION_CTRL:  rd_mux[7:0] = option_control_reg;
      tws_pkg::OFS_WDT_CTRL:     rd_mux[7:0] = watchdog_ctrl_reg;
      tws_pkg::OFS_TIMER_COUNT:  rd_mux[7:0] = timer_count_reg;
      tws_pkg::OFS_STATUS_FLAGS: rd_mux[7:0] = status_flags_reg;
      tws_pkg::OFS_IRQ_FLAG:     rd_mux[7:0] = irq_flag_reg;
      tws_pkg::OFS_IRQ_MASK:     rd_mux[7:0] = irq_mask_reg;
      tws_pkg::OFS_PULL_DOWN:    rd_mux[7:0] = pull_down_ctrl_reg;
      tws_pkg::OFS_OPEN_DRAIN:   rd_mux[7:0] = open_drain_ctrl_reg;
      tws_pkg::OFS_PULL_UP:      rd_mux[7:0] = pull_up_ctrl_reg;
      tws_pkg::OFS_PORT2_DATA:   rd_mux[PORT_W-1:0] = i_port2_in;
      tws_pkg::OFS_COMMAND:      rd_mux[0] = irq_on_reg;
      tws_pkg::OFS_PROG_COUNTER: rd_mux[PC_W-1:0] = program_counter_reg;
      default:                   rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      prdata_reg <= 32'h00000000;
    end else if (setup_rd) begin
      prdata_reg <= rd_mux;
    end
  end

  // Wake pulse register
  logic wake_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_chg;
    end
  end

  // Outputs
  assign o_pready          = 1'b1;
  assign o_pslverr         = i_psel & i_penable & ~mapped;
  assign o_prdata          = prdata_reg;
  assign o_device_reset    = hold_reg;
  assign o_ports_hiz       = hold_reg;
  assign o_sleep           = sleep_reg;
  assign o_wake_pulse      = wake_reg;
  assign o_program_counter = program_counter_reg;
  assign o_pull_down_ctrl  = pull_down_ctrl_reg;
  assign o_open_drain_ctrl = open_drain_ctrl_reg;
  assign o_pull_up_ctrl    = pull_up_ctrl_reg;

endmodule : tws_timer_watchdog

// file: tws_pkg.sv
// Package for the timer, watchdog, sleep and wake block.
// Assumes a 250 MHz core clock and a 32-bit APB register port.
package tws_pkg;

  // Clock and long timing figures
  localparam int unsigned CORE_CLK_MHZ     = 250;
  localparam int unsigned WDT_TIMEOUT_US   = 18000;
  localparam int unsigned START_HOLD_US    = 18000;
  localparam int unsigned WDT_TIMEOUT_CYC  = WDT_TIMEOUT_US * CORE_CLK_MHZ;
  localparam int unsigned WDT_TICK_CYC     = WDT_TIMEOUT_CYC / 256;
  localparam int unsigned START_HOLD_CYC   = START_HOLD_US * CORE_CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] OFS_OPTION_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WDT_CTRL      = 8'h04;
  localparam logic [7:0] OFS_TIMER_COUNT   = 8'h08;
  localparam logic [7:0] OFS_STATUS_FLAGS  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_FLAG      = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK      = 8'h14;
  localparam logic [7:0] OFS_PULL_DOWN     = 8'h18;
  localparam logic [7:0] OFS_OPEN_DRAIN    = 8'h1C;
  localparam logic [7:0] OFS_PULL_UP       = 8'h20;
  localparam logic [7:0] OFS_PORT2_DATA    = 8'h24;
  localparam logic [7:0] OFS_COMMAND       = 8'h28;
  localparam logic [7:0] OFS_PROG_COUNTER  = 8'h2C;

  // Option control fields
  localparam int unsigned OPT_PSEL_LSB     = 0;
  localparam int unsigned OPT_BYPASS_BIT   = 3;
  localparam int unsigned OPT_EDGE_BIT     = 4;
  localparam int unsigned OPT_SRC_BIT      = 5;
  localparam int unsigned OPT_INTF_BIT     = 6;

  // Watchdog control fields
  localparam int unsigned WDC_EN_BIT       = 7;
  localparam int unsigned WDC_PSE_BIT      = 5;
  localparam int unsigned WDC_PSEL_LSB     = 2;
  localparam logic [7:0]  WDC_WMASK        = 8'hFC;

  // Status flags fields
  localparam int unsigned STS_TO_BIT       = 4;
  localparam int unsigned STS_PD_BIT       = 3;
  localparam logic [7:0]  STS_WMASK        = 8'hE7;
  localparam logic [7:0]  STS_POR_MASK     = 8'h1F;

  // Interrupt flag bits
  localparam int unsigned IRQ_TMR_BIT      = 0;
  localparam int unsigned IRQ_CHG_BIT      = 1;
  localparam logic [7:0]  IRQ_WMASK        = 8'h1F;

  // Command bits
  localparam int unsigned CMD_CLRWDT_BIT   = 0;
  localparam int unsigned CMD_SLEEP_BIT    = 1;
  localparam int unsigned CMD_IRQ_ON_BIT   = 2;
  localparam int unsigned CMD_IRQ_OFF_BIT  = 3;

  // Reset values
  localparam logic [7:0] RST_OPTION_CTRL   = 8'hBF;
  localparam logic [7:0] RST_WDT_CTRL      = 8'h80;
  localparam logic [7:0] RST_PULL_DOWN     = 8'hFF;
  localparam logic [7:0] RST_OPEN_DRAIN    = 8'h00;
  localparam logic [7:0] RST_PULL_UP       = 8'hFF;
  localparam logic [7:0] RST_IRQ           = 8'h00;
  localparam logic [7:0] RST_STATUS        = 8'h18;

  // Port-change wake vector
  localparam logic [9:0] WAKE_VECTOR       = 10'h006;

endpackage : tws_pkg

// file: tws_timer_watchdog_properties.sv
// Checker for the timer and watchdog block, port relations only.
// Assumes the bound instance's hold length and counter width.
`timescale 1ns/10ps
module tws_timer_watchdog_chk #(
  parameter int unsigned START_HOLD_CYC = 8,
  parameter int unsigned PC_W           = 10
) (
  // Clock and reset
  input wire logic            i_core_clk,
  input wire logic            i_reset,
  // APB request
  input wire logic            i_psel,
  input wire logic            i_penable,
  input wire logic            i_pwrite,
  input wire logic [7:0]      i_paddr,
  input wire logic [31:0]     i_pwdata,
  // Pins and status
  input wire logic            i_ext_reset_n,
  input wire logic            o_device_reset,
  input wire logic            o_ports_hiz,
  input wire logic            o_sleep,
  input wire logic            o_wake_pulse,
  input wire logic [PC_W-1:0] o_program_counter
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // Counts visible hold cycles; a lower bound only, trigger lag unknown
  int unsigned hold_cnt;
  always_ff @(posedge i_core_clk) begin
    if (i_reset || !i_ext_reset_n || !o_device_reset) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= hold_cnt + 1;
    end
  end
  AST_EXT_RESET: assert property (
    !i_ext_reset_n |-> ##[1:2] o_device_reset)
    else $error("reset pin low without device reset");
  AST_HOLD_LEN: assert property (
    $fell(o_device_reset) |-> hold_cnt >= START_HOLD_CYC)
    else $error("reset hold too short");
  AST_HIZ: assert property (o_ports_hiz == o_device_reset)
    else $error("ports not floated with reset");
  AST_PC_CLEAR: assert property (
    o_device_reset && $past(o_device_reset) |-> o_program_counter == '0)
    else $error("counter not zero in reset");
  AST_SLEEP_CMD: assert property (
    i_psel && i_penable && i_pwrite && i_pwdata[1] && !o_device_reset
    && i_paddr == tws_pkg::OFS_COMMAND |-> ##[1:2] o_sleep)
    else $error("sleep command ignored");
  AST_WAKE_PULSE: assert property (
    $fell(o_sleep) && !o_device_reset && i_ext_reset_n
    && $past(i_ext_reset_n) |-> o_wake_pulse)
    else $error("wake without pulse");
  AST_WAKE_SINGLE: assert property (
    o_wake_pulse |=> !o_wake_pulse)
    else $error("wake pulse too long");
  AST_WAKE_AWAKE: assert property (
    o_wake_pulse |-> !o_sleep && !o_device_reset)
    else $error("wake pulse while asleep or in reset");
  cover property ($rose(o_sleep));
  cover property (o_wake_pulse);
  cover property ($rose(o_device_reset));
endmodule : tws_timer_watchdog_chk

bind tws_timer_watchdog tws_timer_watchdog_chk #(
  .START_HOLD_CYC(START_HOLD_CYC), .PC_W(PC_W)
) i_tws_timer_watchdog_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_ext_reset_n(i_ext_reset_n),
  .o_device_reset(o_device_reset), .o_ports_hiz(o_ports_hiz),
  .o_sleep(o_sleep), .o_wake_pulse(o_wake_pulse),
  .o_program_counter(o_program_counter));

// file: tws_pin_model.sv
// Pin-side model: timer input, second port levels, reset pin.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/10ps
module tws_pin_model (
  // Clock
  input  wire logic  i_core_clk,
  // Pins
  output logic       o_timer_pin,
  output logic [7:0] o_port2,
  output logic       o_ext_reset_n
);
  initial begin
    o_timer_pin   = 1'b0;
    o_port2       = 8'h00;
    o_ext_reset_n = 1'b1;
  end
  // Three clocks a level, so no edge is lost
  task automatic toggle(input int n);
    for (int j = 0; j < n; j++) begin
      o_timer_pin <= ~o_timer_pin;
      repeat (3) @(posedge i_core_clk);
    end
  endtask : toggle
  task automatic set_port(input logic [7:0] v);
    o_port2 <= v;
  endtask : set_port
  task automatic pulse_reset;
    o_ext_reset_n <= 1'b0;
    @(posedge i_core_clk);
    o_ext_reset_n <= 1'b1;
  endtask : pulse_reset
endmodule : tws_pin_model

// file: tws_timer_watchdog_bench.sv
// Bench: reset values, timer, sleep, wake and watchdog time-out.
// Assumes the pin model owns the timer pin, second port and reset pin.
`timescale 1ns/10ps
module tws_timer_watchdog_bench;
  localparam int TICK = 4;
  logic        i_core_clk = 1'b0;
  logic        i_reset    = 1'b1;
  logic        i_psel     = 1'b0;
  logic        i_penable  = 1'b0;
  logic        i_pwrite   = 1'b0;
  logic [7:0]  i_paddr    = 8'h00;
  logic [31:0] i_pwdata   = 32'h0;
  logic        o_pready, o_pslverr, o_device_reset, o_ports_hiz;
  logic        o_sleep, o_wake_pulse, i_ext_reset_n, i_timer_pin;
  logic [31:0] o_prdata, rd;
  logic [7:0]  i_port2_in, pull_dn, open_dr, pull_up;
  logic [9:0]  o_program_counter;
  logic [7:0]  lfsr       = 8'h42;
  int          failures   = 0;
  int          n_compared = 0;
  logic [7:0] reg_a[8] = '{tws_pkg::OFS_OPTION_CTRL, tws_pkg::OFS_WDT_CTRL,
    tws_pkg::OFS_PULL_DOWN, tws_pkg::OFS_OPEN_DRAIN, tws_pkg::OFS_PULL_UP,
    tws_pkg::OFS_IRQ_FLAG, tws_pkg::OFS_IRQ_MASK, tws_pkg::OFS_STATUS_FLAGS};
  logic [7:0] reg_v[8] = '{8'hBF, 8'h80, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00,
    8'h18};

  always #2 i_core_clk = ~i_core_clk;

  tws_timer_watchdog #(.WDT_TICK_CYC(TICK), .START_HOLD_CYC(8))
  i_tws_timer_watchdog (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_prdata(o_prdata), .i_ext_reset_n(i_ext_reset_n),
    .i_timer_pin(i_timer_pin), .i_port2_in(i_port2_in),
    .o_device_reset(o_device_reset), .o_ports_hiz(o_ports_hiz),
    .o_sleep(o_sleep), .o_wake_pulse(o_wake_pulse),
    .o_program_counter(o_program_counter), .o_pull_down_ctrl(pull_dn),
    .o_open_drain_ctrl(open_dr), .o_pull_up_ctrl(pull_up));

  tws_pin_model i_tws_pin_model (.i_core_clk(i_core_clk),
    .o_timer_pin(i_timer_pin), .o_port2(i_port2_in),
    .o_ext_reset_n(i_ext_reset_n));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  function automatic logic pick(input int w);
    return w == 0 ? o_device_reset : w == 1 ? o_sleep : o_wake_pulse;
  endfunction : pick

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : check

  task automatic results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic bad_end;
    failures++;
    $display("BAD %0t wait ran out", $time);
    results;
  endtask : bad_end

  // 0 device reset, 1 sleep, 2 wake pulse
  task automatic wait_sig(input int w, input logic v, input int lim,
                          output int n);
    n = 0;
    while (pick(w) !== v) begin
      if (n == lim) bad_end;
      @(posedge i_core_clk);
      n++;
    end
  endtask : wait_sig

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic err);
    int n;
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
      if (n > 20) bad_end;
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    check({31'h0, o_pslverr}, {31'h0, err});
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_core_clk);
  endtask : apb

  initial begin
    logic [9:0] pc;
    logic [7:0] ctl;
    logic       lv;
    int         n, cnt, want;
    repeat (6) @(posedge i_core_clk);
    i_reset <= 1'b0;
    wait_sig(0, 1'b0, 40, n);
    foreach (reg_a[k]) begin
      apb(1'b0, reg_a[k], 8'h00, 1'b0);
      check(rd, {24'h0, reg_v[k]});
    end
    check({8'h0, pull_dn, open_dr, pull_up}, 32'h00FF00FF);
    apb(1'b0, 8'hFC, 8'h00, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, tws_pkg::OFS_WDT_CTRL, 8'h20, 1'b0);
    apb(1'b1, tws_pkg::OFS_OPTION_CTRL, 8'h08, 1'b0);
    apb(1'b0, tws_pkg::OFS_TIMER_COUNT, 8'h00, 1'b0);
    want = (rd + 3) % 256;
    apb(1'b0, tws_pkg::OFS_TIMER_COUNT, 8'h00, 1'b0);
    check(rd, want);
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      apb(1'b1, tws_pkg::OFS_OPTION_CTRL, 8'(k), 1'b0);
      apb(1'b1, tws_pkg::OFS_TIMER_COUNT, lfsr, 1'b0);
      repeat ((4 << (k + 1)) - 2) @(posedge i_core_clk);
      apb(1'b0, tws_pkg::OFS_TIMER_COUNT, 8'h00, 1'b0);
      ctl = rd[7:0] - lfsr;
      check({31'h0, ctl == 8'h03 || ctl == 8'h04}, 32'h1);
    end
    for (int e = 0; e < 2; e++) begin
      lfsr = lfsr_next(lfsr);
      apb(1'b1, tws_pkg::OFS_OPTION_CTRL, e ? 8'h38 : 8'h28, 1'b0);
      apb(1'b1, tws_pkg::OFS_TIMER_COUNT, 8'h00, 1'b0);
      lv = i_timer_pin;
      cnt = 0;
      n = lfsr % 8 + 1;
      for (int j = 0; j < n; j++) begin
        lv = ~lv;
        if (lv != e[0]) cnt++;
      end
      i_tws_pin_model.toggle(n);
      repeat (3) @(posedge i_core_clk);
      apb(1'b0, tws_pkg::OFS_TIMER_COUNT, 8'h00, 1'b0);
      check(rd, cnt);
    end
    for (int m = 0; m < 2; m++) begin
      apb(1'b0, tws_pkg::OFS_PORT2_DATA, 8'h00, 1'b0);
      apb(1'b1, tws_pkg::OFS_IRQ_MASK, 8'h02, 1'b0);
      apb(1'b1, tws_pkg::OFS_COMMAND, m ? 8'h04 : 8'h08, 1'b0);
      apb(1'b1, tws_pkg::OFS_PROG_COUNTER, lfsr, 1'b0);
      pc = {2'h0, lfsr};
      apb(1'b1, tws_pkg::OFS_COMMAND, 8'h02, 1'b0);
      wait_sig(1, 1'b1, 5, n);
      apb(1'b0, tws_pkg::OFS_STATUS_FLAGS, 8'h00, 1'b0);
      check(rd & 32'h18, 32'h10);
      lfsr = lfsr_next(lfsr);
      i_tws_pin_model.set_port(lfsr == i_port2_in ? ~lfsr : lfsr);
      wait_sig(2, 1'b1, 10, n);
      check({22'h0, o_program_counter}, {22'h0, m ? 10'h006 : pc});
      apb(1'b0, tws_pkg::OFS_WDT_CTRL, 8'h00, 1'b0);
      check(rd & 32'h80, 32'h80);
      apb(1'b1, tws_pkg::OFS_WDT_CTRL, 8'h20, 1'b0);
      apb(1'b1, tws_pkg::OFS_IRQ_MASK, 8'h00, 1'b0);
    end
    apb(1'b1, tws_pkg::OFS_COMMAND, 8'h02, 1'b0);
    wait_sig(1, 1'b1, 5, n);
    i_tws_pin_model.pulse_reset;
    wait_sig(0, 1'b1, 5, n);
    wait_sig(0, 1'b0, 40, n);
    apb(1'b0, tws_pkg::OFS_STATUS_FLAGS, 8'h00, 1'b0);
    check(rd & 32'h18, 32'h10);
    check({31'h0, o_sleep}, 32'h0);
    for (int k = 0; k < 5; k++) begin
      ctl = (k == 0) ? 8'h80 : (8'hA0 | 8'((k - 1) << 2));
      apb(1'b1, tws_pkg::OFS_WDT_CTRL, ctl, 1'b0);
      apb(1'b1, tws_pkg::OFS_COMMAND, k ? 8'h01 : 8'h02, 1'b0);
      wait_sig(0, 1'b1, 20000, n);
      want = 256 * TICK << k;
      check({31'h0, n > want - 12 && n < want + 12}, 32'h1);
      wait_sig(0, 1'b0, 40, n);
      apb(1'b0, tws_pkg::OFS_STATUS_FLAGS, 8'h00, 1'b0);
      check(rd & 32'h18, k ? 32'h08 : 32'h00);
    end
    results;
  end
endmodule : tws_timer_watchdog_bench
